// ### bench/timer_control_regs_sva.sv
// checker for the timer control nibble registers, port level only
// assumes one clock domain and a bind onto timer_control_regs
`timescale 1ns/1ps
module timer_control_regs_sva #(
  parameter DIV_W = 24
) (
  // clock, reset and reset causes
  input wire REF_CLK_I,
  input wire RST_I,
  input wire WDOG_RESET_I,
  input wire CE_RESET_I,
  input wire CLOCK_STOP_I,
  // register port
  input wire [5:0] ADDR_I,
  input wire [3:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [3:0] RDATA_O,
  // timer side
  input wire T0_OVERFLOW_I,
  input wire [3:0] RUN_O,
  input wire [3:0] CLEAR_O,
  input wire [3:0] TICK_O,
  input wire BASE_TICK_O,
  input wire T3_DAC_CHOICE_O,
  input wire T0_GATE_CLOSE_EDGE_O,
  input wire T0_GATE_OPEN_EDGE_O,
  input wire T0_COUNT_STYLE_O,
  input wire IRQ_O
);
  // one domain, reset disables all
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // write effects on control outputs
  property p_clr0;
    WR_I && ADDR_I == 6'h2B |=> CLEAR_O[0] == $past(WDATA_I[2]);
  endproperty
  a_clr0: assert property (p_clr0) else $error("clear pulse lost");
  property p_clr_cause;
    CLEAR_O[0] |-> $past(WR_I && ADDR_I == 6'h2B && WDATA_I[2]);
  endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("stray clear");
  property p_run0;
    WR_I && ADDR_I == 6'h2B && !CLOCK_STOP_I |=>
      RUN_O[0] == $past(WDATA_I[3]);
  endproperty
  a_run0: assert property (p_run0) else $error("run bit wrong");
  property p_t3;
    WR_I && ADDR_I == 6'h28 |=> T3_DAC_CHOICE_O == $past(WDATA_I[3])
      && RUN_O[3] == $past(WDATA_I[1]);
  endproperty
  a_t3: assert property (p_t3) else $error("timer 3 bits wrong");
  property p_mode;
    WR_I && ADDR_I == 6'h2C |=> {T0_GATE_CLOSE_EDGE_O, T0_GATE_OPEN_EDGE_O,
      T0_COUNT_STYLE_O} == $past(WDATA_I[2:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  // read data only after a read
  property p_rd_idle;
    !RD_I |=> RDATA_O == 4'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data idle");
  property p_rd_run;
    RD_I && ADDR_I == 6'h2A |=> RDATA_O[3:2] == {RUN_O[1], 1'b0};
  endproperty
  a_rd_run: assert property (p_rd_run) else $error("read of run");
  // tick pulses and clock stop
  property p_tick;
    TICK_O[0] |=> !TICK_O[0] && TICK_O[3] == 1'b0;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_stop;
    CLOCK_STOP_I [*4] |-> RUN_O == 4'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("run kept in stop");
  c_clr: cover property (CLEAR_O[0]);
  c_stop: cover property (CLOCK_STOP_I [*4]);
  c_irq: cover property (IRQ_O);
endmodule // timer_control_regs_sva

bind timer_control_regs timer_control_regs_sva #(.DIV_W(DIV_W))
  timer_control_regs_sva_i (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .WDOG_RESET_I(WDOG_RESET_I), .CE_RESET_I(CE_RESET_I),
  .CLOCK_STOP_I(CLOCK_STOP_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .T0_OVERFLOW_I(T0_OVERFLOW_I), .RUN_O(RUN_O), .CLEAR_O(CLEAR_O),
  .TICK_O(TICK_O), .BASE_TICK_O(BASE_TICK_O),
  .T3_DAC_CHOICE_O(T3_DAC_CHOICE_O),
  .T0_GATE_CLOSE_EDGE_O(T0_GATE_CLOSE_EDGE_O),
  .T0_GATE_OPEN_EDGE_O(T0_GATE_OPEN_EDGE_O),
  .T0_COUNT_STYLE_O(T0_COUNT_STYLE_O), .IRQ_O(IRQ_O));

// ### bench/timer_control_regs_test.sv
// self-checking bench for the timer control nibble registers
// assumes a 100 MHz clock and the one-cycle nibble register port
`timescale 1ns/1ps
module timer_control_regs_test;
  logic ref_clk, rst, wdog, ce, stop, wr, rd, ovf;
  logic [5:0] addr;
  logic [3:0] wdata, rdata, run, clr, tick, v;
  logic base, t3c, gce, goe, sty, irq;
  int mismatches, checks, cycles, g;
  typedef struct packed {logic [5:0] a; logic [3:0] d, r, c, u;} row_t;
  // address, write, readback, clear pulses, run levels
  row_t rows [8] = '{'{6'h28, 4'hF, 4'hA, 4'h8, 4'h8},
    '{6'h29, 4'hF, 4'hB, 4'h4, 4'hC}, '{6'h2A, 4'h7, 4'h3, 4'h2, 4'hC},
    '{6'h2B, 4'hE, 4'hA, 4'h1, 4'hD}, '{6'h2C, 4'hF, 4'h7, 4'h0, 4'hD},
    '{6'h18, 4'hF, 4'h3, 4'h0, 4'hD}, '{6'h31, 4'h0, 4'h0, 4'h0, 4'hD},
    '{6'h3F, 4'hF, 4'h0, 4'h0, 4'hD}};
  timer_control_regs timer_control_regs_i (.REF_CLK_I(ref_clk),
    .RST_I(rst), .WDOG_RESET_I(wdog), .CE_RESET_I(ce),
    .CLOCK_STOP_I(stop), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .T0_OVERFLOW_I(ovf), .RUN_O(run),
    .CLEAR_O(clr), .TICK_O(tick), .BASE_TICK_O(base),
    .T3_DAC_CHOICE_O(t3c), .T0_GATE_CLOSE_EDGE_O(gce),
    .T0_GATE_OPEN_EDGE_O(goe), .T0_COUNT_STYLE_O(sty), .IRQ_O(irq));
  // clock and hang limit
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end
  // verdict
  task close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // bus cycles, entered at an edge, left one edge after the strobe
  task reg_wr(input logic [5:0] a, input logic [3:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task reg_rd(input logic [5:0] a, output logic [3:0] q);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
    q = rdata;
  endtask
  task waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // cycles between two tick pulses of timer k
  task tick_gap(input int k, output int gap);
    int n;
    n = 0;
    gap = 0;
    do begin waitc(1); n++; end while (tick[k] !== 1'b1 && n < 20000);
    do begin waitc(1); gap++; end while (tick[k] !== 1'b1 && gap < 20000);
  endtask
  // main sequence
  initial begin
    {ref_clk, wdog, ce, stop, wr, rd, ovf, addr, wdata} = '0;
    {mismatches, checks, cycles} = '0;
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    waitc(1);
    foreach (rows[i]) begin
      reg_rd(rows[i].a, v);
      chk(v, 4'h0);
    end
    chk({3'h0, base}, 4'h0);
    chk({t3c, gce, goe, sty}, 4'h0);
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      chk(clr, rows[i].c);
      reg_rd(rows[i].a, v);
      chk(v, rows[i].r);
      chk(run, rows[i].u);
    end
    chk({t3c, gce, goe, sty}, 4'hF);
    // timers 0, 1, 2 at 100 kHz, then timer 0 at 10 kHz
    for (int r = 0; r < 4; r++) begin
      reg_wr(6'h2B - 6'(r % 3), (r == 3) ? 4'h9 : 4'h8);
      tick_gap(r % 3, g);
      checks++;
      if (g != ((r == 3) ? 10000 : 1000)) begin
        mismatches++;
        $display("MISMATCH %0t tick gap %0d", $time, g);
      end
    end
    ce <= 1'b1;
    waitc(2);
    ce <= 1'b0;
    waitc(5);
    reg_rd(6'h2B, v);
    chk(v, 4'h9);
    stop <= 1'b1;
    waitc(5);
    chk(run, 4'h0);
    stop <= 1'b0;
    waitc(5);
    reg_rd(6'h2B, v);
    chk(v, 4'h0);
    reg_rd(6'h18, v);
    chk(v, 4'h3);
    wdog <= 1'b1;
    waitc(5);
    wdog <= 1'b0;
    waitc(5);
    reg_rd(6'h17, v);
    chk(v, 4'h1);
    reg_rd(6'h17, v);
    chk(v, 4'h0);
    reg_rd(6'h18, v);
    chk(v, 4'h0);
    reg_wr(6'h2B, 4'h8);
    ovf <= 1'b1;
    waitc(1);
    ovf <= 1'b0;
    waitc(4);
    reg_rd(6'h2C, v);
    chk(v, 4'h8);
    reg_wr(6'h31, 4'h2);
    chk({3'h0, irq}, 4'h1);
    reg_wr(6'h31, 4'h0);
    chk({3'h0, irq}, 4'h0);
    reg_wr(6'h31, 4'h2);
    reg_wr(6'h30, 4'h2);
    chk({3'h0, irq}, 4'h0);
    reg_wr(6'h2B, 4'hC);
    reg_rd(6'h2C, v);
    chk(v, 4'h0);
    close_out();
  end
endmodule // timer_control_regs_test

// ### hw/rate_strobe.v
// rate strobe: a free divider giving one-cycle pulses at a chosen rate
// assumes the period is set from a constant table and held steady
`timescale 1ns/1ps
module rate_strobe #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire clear_i,
  // period in clock cycles
  input wire [WIDTH-1:0] period_i,
  // pulse out
  output reg pulse_o
);
  reg [WIDTH-1:0] count_reg;
  // count up, pulse at wrap
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= {WIDTH{1'b0}};
      pulse_o <= 1'b0;
    end else if (clear_i) begin
      count_reg <= {WIDTH{1'b0}};
      pulse_o <= 1'b0;
    end else if (count_reg >= period_i - 1'b1) begin
      count_reg <= {WIDTH{1'b0}};
      pulse_o <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      pulse_o <= 1'b0;
    end
  end
endmodule // rate_strobe

// ### hw/timer_control_regs.v
// timer group control and status nibble registers with tick strobes
// assumes strobes from same clock; system reset causes arrive as pins
//
// Operation
// - carry flag reads 1 when set; read clears; power-on 0, chip-enable sets
// - two-bit base tick rate: 10, 20, 50, 100 Hz
// - select bit: 0 gives shared resource to converter, 1 to timer 3
// - timer 3 run bit stops counter at 0, counts at 1
// - writing 1 to timer 3 clear bit resets its counter
// - timers 0 to 2 each have a run bit, stop 0, count 1
// - writing 1 to a timer 0 to 2 clear bit resets that counter
// - timers 0 to 2 pick count clock 100k, 10k, 2k, 1k Hz
// - timer 0 overflow bit reads 1 once overflow happened
// - gate close edge bit: 0 rising, 1 falling
// - gate open edge bit chooses its edge independently
`timescale 1ns/1ps
`include "timer_ctl_map.vh"
module timer_control_regs #(
  parameter DIV_W = 24
) (
  // clock and reset
  input wire REF_CLK_I,
  input wire RST_I,
  // reset causes and clock stop, asynchronous pins
  input wire WDOG_RESET_I,
  input wire CE_RESET_I,
  input wire CLOCK_STOP_I,
  // register port
  input wire [5:0] ADDR_I,
  input wire [3:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [3:0] RDATA_O,
  // events from counter datapath
  input wire T0_OVERFLOW_I,
  // timer controls
  output wire [3:0] RUN_O,
  output wire [3:0] CLEAR_O,
  output wire [3:0] TICK_O,
  output wire BASE_TICK_O,
  output wire T3_DAC_CHOICE_O,
  output wire T0_GATE_CLOSE_EDGE_O,
  output wire T0_GATE_OPEN_EDGE_O,
  output wire T0_COUNT_STYLE_O,
  // interrupt
  output wire IRQ_O
);
  // period in cycles for a two-bit counter rate code
  function [DIV_W-1:0] cnt_period;
    input [1:0] code;
    integer whole;
    begin
      case (code)
        2'h0: whole = `CLK_HZ / `HZ_100K;
        2'h1: whole = `CLK_HZ / `HZ_10K;
        2'h2: whole = `CLK_HZ / `HZ_2K;
        default: whole = `CLK_HZ / `HZ_1K;
      endcase
      cnt_period = whole[DIV_W-1:0]; // cut to the divider width
    end
  endfunction

  // period in cycles for the base tick rate code
  function [DIV_W-1:0] tick_period;
    input [1:0] code;
    integer whole;
    begin
      case (code)
        2'h0: whole = `CLK_HZ / `HZ_10;
        2'h1: whole = `CLK_HZ / `HZ_20;
        2'h2: whole = `CLK_HZ / `HZ_50;
        default: whole = `CLK_HZ / `HZ_100;
      endcase
      tick_period = whole[DIV_W-1:0]; // 10 Hz still fits 24 bits
    end
  endfunction

  reg [2:0] wd_s1_reg, wd_s2_reg;
  wire wd_sync, ce_sync, stop_sync;
  reg ce_prev_reg;
  wire ce_rise;
  reg carry_reg;
  reg [1:0] rate_reg;
  reg t3_choice_reg;
  reg [3:0] run_reg;
  reg [3:0] clear_reg;
  reg [1:0] t0_rate_reg, t1_rate_reg, t2_rate_reg;
  reg ovf_reg, close_edge_reg, open_edge_reg, style_reg;
  reg [1:0] irq_stat_reg, irq_mask_reg;
  reg [3:0] rdata_next;
  wire base_pulse;
  wire ctl_clear;
  reg ovf_prev_reg;
  wire ovf_event;
  wire read_carry;

  // two-flop synchronisers for the pin inputs
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wd_s1_reg <= 3'h0;
      wd_s2_reg <= 3'h0;
    end else begin
      wd_s1_reg <= {WDOG_RESET_I, CE_RESET_I, CLOCK_STOP_I};
      wd_s2_reg <= wd_s1_reg;
    end
  end
  assign wd_sync = wd_s2_reg[2];
  assign ce_sync = wd_s2_reg[1];
  assign stop_sync = wd_s2_reg[0];
  assign ce_rise = ce_sync & ~ce_prev_reg;
  assign ctl_clear = wd_sync | stop_sync;
  assign read_carry = RD_I && (ADDR_I == `OFS_CARRY);
  assign ovf_event = T0_OVERFLOW_I & ~ovf_prev_reg;

  // edge history
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ce_prev_reg <= 1'b0;
      ovf_prev_reg <= 1'b0;
    end else begin
      ce_prev_reg <= ce_sync;
      ovf_prev_reg <= T0_OVERFLOW_I;
    end
  end

  // carry flip-flop: set by tick or chip-enable reset, cleared by read
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      carry_reg <= 1'b0;
    end else if (base_pulse || ce_rise) begin
      carry_reg <= 1'b1;
    end else if (read_carry) begin
      carry_reg <= 1'b0;
    end
  end

  // base tick rate: cleared on watchdog reset, kept on clock stop
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rate_reg <= 2'h0;
    end else if (wd_sync) begin
      rate_reg <= 2'h0;
    end else if (WR_I && ADDR_I == `OFS_TICK_RATE) begin
      rate_reg <= WDATA_I[1:0];
    end
  end

  // control registers of timers 0 to 3
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      t3_choice_reg <= 1'b0;
      run_reg <= `RST_NIBBLE;
      clear_reg <= `RST_NIBBLE;
      t0_rate_reg <= 2'h0;
      t1_rate_reg <= 2'h0;
      t2_rate_reg <= 2'h0;
      close_edge_reg <= 1'b0;
      open_edge_reg <= 1'b0;
      style_reg <= 1'b0;
    end else if (ctl_clear) begin
      t3_choice_reg <= 1'b0;
      run_reg <= `RST_NIBBLE;
      clear_reg <= `RST_NIBBLE;
      t0_rate_reg <= 2'h0;
      t1_rate_reg <= 2'h0;
      t2_rate_reg <= 2'h0;
      close_edge_reg <= 1'b0;
      open_edge_reg <= 1'b0;
      style_reg <= 1'b0;
    end else begin
      clear_reg <= `RST_NIBBLE; // clear is a one-cycle pulse
      if (WR_I) begin
        case (ADDR_I)
          `OFS_T3_CTL: begin
            t3_choice_reg <= WDATA_I[`POS_T3_CHOICE];
            run_reg[3] <= WDATA_I[1];
            clear_reg[3] <= WDATA_I[0];
          end
          `OFS_T2_CTL: begin
            run_reg[2] <= WDATA_I[`POS_RUN];
            clear_reg[2] <= WDATA_I[`POS_CLEAR];
            t2_rate_reg <= WDATA_I[1:0];
          end
          `OFS_T1_CTL: begin
            run_reg[1] <= WDATA_I[`POS_RUN];
            clear_reg[1] <= WDATA_I[`POS_CLEAR];
            t1_rate_reg <= WDATA_I[1:0];
          end
          `OFS_T0_CTL: begin
            run_reg[0] <= WDATA_I[`POS_RUN];
            clear_reg[0] <= WDATA_I[`POS_CLEAR];
            t0_rate_reg <= WDATA_I[1:0];
          end
          `OFS_T0_MODE: begin
            close_edge_reg <= WDATA_I[`POS_CLOSE_EDGE];
            open_edge_reg <= WDATA_I[`POS_OPEN_EDGE];
            style_reg <= WDATA_I[`POS_STYLE];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // overflow status: set by overflow, cleared by watchdog reset, clock stop or timer 0 clear
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ovf_reg <= 1'b0;
    end else if (ovf_event) begin
      ovf_reg <= 1'b1;
    end else if (ctl_clear || clear_reg[0]) begin
      ovf_reg <= 1'b0;
    end
  end

  // interrupt status and mask, write one to clear, set wins
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end else begin
      if (WR_I && ADDR_I == `OFS_IRQ_MASK) begin
        irq_mask_reg <= WDATA_I[1:0];
      end
      irq_stat_reg <= (irq_stat_reg
        & ~((WR_I && ADDR_I == `OFS_IRQ_STATUS) ? WDATA_I[1:0] : 2'h0))
        | {ovf_event, base_pulse};
    end
  end
  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  // read mux, unused bits and unmapped offsets read zero
  always @* begin
    rdata_next = 4'h0;
    case (ADDR_I)
      `OFS_CARRY: rdata_next = {3'h0, carry_reg};
      `OFS_TICK_RATE: rdata_next = {2'h0, rate_reg};
      `OFS_T3_CTL: rdata_next = {t3_choice_reg, 1'b0, run_reg[3], 1'b0};
      `OFS_T2_CTL: rdata_next = {run_reg[2], 1'b0, t2_rate_reg};
      `OFS_T1_CTL: rdata_next = {run_reg[1], 1'b0, t1_rate_reg};
      `OFS_T0_CTL: rdata_next = {run_reg[0], 1'b0, t0_rate_reg};
      `OFS_T0_MODE: rdata_next = {ovf_reg, close_edge_reg,
        open_edge_reg, style_reg};
      `OFS_IRQ_STATUS: rdata_next = {2'h0, irq_stat_reg};
      `OFS_IRQ_MASK: rdata_next = {2'h0, irq_mask_reg};
      default: rdata_next = 4'h0;
    endcase
  end

  // read data register, valid the cycle after the strobe
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 4'h0;
    end else if (RD_I) begin
      RDATA_O <= rdata_next;
    end else begin
      RDATA_O <= 4'h0;
    end
  end

  // base tick divider
  rate_strobe #(.WIDTH(DIV_W)) u_base (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clear_i(1'b0),
    .period_i(tick_period(rate_reg)),
    .pulse_o(base_pulse)
  );

  // count clock strobes for timers 0 to 2, cleared to zero while stopped
  rate_strobe #(.WIDTH(DIV_W)) u_t0 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clear_i(~run_reg[0] | clear_reg[0]),
    .period_i(cnt_period(t0_rate_reg)),
    .pulse_o(TICK_O[0])
  );
  rate_strobe #(.WIDTH(DIV_W)) u_t1 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clear_i(~run_reg[1] | clear_reg[1]),
    .period_i(cnt_period(t1_rate_reg)),
    .pulse_o(TICK_O[1])
  );
  rate_strobe #(.WIDTH(DIV_W)) u_t2 (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .clear_i(~run_reg[2] | clear_reg[2]),
    .period_i(cnt_period(t2_rate_reg)),
    .pulse_o(TICK_O[2])
  );
  assign TICK_O[3] = 1'b0; // timer 3 counts an external source

  // control outputs
  assign RUN_O = run_reg;
  assign CLEAR_O = clear_reg;
  assign BASE_TICK_O = base_pulse;
  assign T3_DAC_CHOICE_O = t3_choice_reg;
  assign T0_GATE_CLOSE_EDGE_O = close_edge_reg;
  assign T0_GATE_OPEN_EDGE_O = open_edge_reg;
  assign T0_COUNT_STYLE_O = style_reg;
endmodule // timer_control_regs

// ### hw/timer_ctl_map.vh
// register offsets, field positions and timing frequencies for timer control
// assumes a 4-bit nibble register port with 6-bit addresses
`ifndef TIMER_CTL_MAP_VH
`define TIMER_CTL_MAP_VH
// register offsets (nibble index)
`define OFS_CARRY 6'h17
`define OFS_TICK_RATE 6'h18
`define OFS_T3_CTL 6'h28
`define OFS_T2_CTL 6'h29
`define OFS_T1_CTL 6'h2A
`define OFS_T0_CTL 6'h2B
`define OFS_T0_MODE 6'h2C
`define OFS_IRQ_STATUS 6'h30
`define OFS_IRQ_MASK 6'h31
// field positions
`define POS_RUN 3
`define POS_CLEAR 2
`define POS_T3_CHOICE 3
`define POS_OVF 3
`define POS_CLOSE_EDGE 2
`define POS_OPEN_EDGE 1
`define POS_STYLE 0
// status bit positions
`define IRQ_CARRY 0
`define IRQ_OVF 1
// reset values
`define RST_NIBBLE 4'h0
// timing: clock rate and tick frequencies in Hz
`define CLK_HZ 100000000
`define HZ_10 10
`define HZ_20 20
`define HZ_50 50
`define HZ_100 100
`define HZ_1K 1000
`define HZ_2K 2000
`define HZ_10K 10000
`define HZ_100K 100000
`endif
